// File: rtl/sps_device.sv
// Self-program flash sequencer, device end
// Function
// - Flash write timed by RC oscillator, 3.7-4.5ms
// - Reset does not abort a running write
// - Boot size fuses pick 512 to 4096 bytes
// - 16K part: blocking region 0x3000-0x3FFF
// - 8K part: readable 0x0000-0x0FFF, blocking above
// - During readable-section erase/write only blocking-region fetches allowed
// - Page holds 64 sixteen-bit words
// - Program counter is 13 bits wide
// - Page select from pointer bits 13:7
// - Word index from pointer bits 6:1
// - Pointer bit 0 kept zero by software
// - Software polls enable bit before commands
// - Software waits for EEPROM write idle
// - Software masks interrupts around timed sequence
// - Section busy stays until re-enable command or a reset outside a timed op
// - Update order: erase, reenable, fill, write
// - Store within four cycles, else dropped
// - Section busy clears by re-enable, or by a reset outside a timed op
// - EEPROM write blocks all programming commands
// - Level interrupt while enable bit clear
`include "sps_cfg.svh"
`timescale 1ns/10ps
module sps_device #(
  parameter bit FLASH_16K  = 1'b1,
  parameter int OSC_KHZ    = `SPS_OSC_KHZ,
  parameter int PROG_TICKS = (`SPS_T_MIN_US * OSC_KHZ + 999) / 1000
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              ce,
  sps_if.dev                     bus,
  input  wire logic              rc_osc,
  input  wire logic              eeprom_write_busy,
  input  wire logic [1:0]        boot_size_sel,
  input  wire logic [12:0]       fetch_addr,
  input  wire logic [5:0]        buf_rd_idx,
  output sps_pkg::sps_op_t       flash_op_q,
  output logic      [6:0]        flash_page_q,
  output logic      [3:0]        flash_lock_q,
  output logic                   flash_done_q,
  output logic      [15:0]       buf_rd_data_q,
  output logic                   rw_section_busy_flag_q,
  output logic                   fetch_ok_q,
  output logic      [15:0]       boot_start_q,
  output logic      [15:0]       app_end_q,
  output logic                   spm_irq_q
);
  localparam logic [15:0] FLASH_BYTES = FLASH_16K ? `SPS_FLASH16 : `SPS_FLASH8;
  localparam logic [15:0] BLOCK_BYTE  = FLASH_16K ? `SPS_NRWW16 : `SPS_NRWW8;
  localparam logic [6:0]  BLOCK_PAGE  = BLOCK_BYTE[13:7];
  localparam logic [12:0] BLOCK_WORD  = BLOCK_BYTE[13:1];
  localparam logic [15:0] TICKS_M1    = 16'(PROG_TICKS - 1);

  sps_pkg::sps_dev_state_t st_q;
  logic [15:0] tick_cnt_q;
  logic        osc_s1_q;
  logic        osc_s2_q;
  logic        osc_s3_q;
  logic        osc_lvl_q;
  logic        osc_prev_q;
  logic        osc_tick;
  logic        self_program_enable_q;
  logic [3:0]  cmd_q;
  logic        ie_q;
  logic [2:0]  win_q;
  logic        prog;
  logic        fire;
  logic        ctl_take;
  logic [15:0] page_buf [0:63];
  logic [1:0]  boot_sel_q;

  // Boot section start from the size fuses; always ends at top of flash
  function automatic logic [15:0] boot_base(input logic [1:0] sel);
    logic [15:0] size;
    size = `SPS_BOOT_MIN << (~sel);
    boot_base = FLASH_BYTES - size;
  endfunction

  assign prog     = (st_q == sps_pkg::SPS_DEV_PROG);
  assign osc_tick = osc_lvl_q && !osc_prev_q;
  // A store counts only while a command is armed and its window is open
  assign fire     = bus.store && self_program_enable_q && !prog && (win_q != 3'h0);
  // EEPROM activity locks the control register against any command
  assign ctl_take = bus.ctrl_wr && !eeprom_write_busy && !prog && !self_program_enable_q;

  // Oscillator sampled through three stages; level moves when 2 and 3 agree
  always_ff @(posedge clk) begin
    if (srst) begin
      osc_s1_q   <= 1'b0;
      osc_s2_q   <= 1'b0;
      osc_s3_q   <= 1'b0;
      osc_lvl_q  <= 1'b0;
      osc_prev_q <= 1'b0;
    end else if (ce) begin
      osc_s1_q   <= rc_osc;
      osc_s2_q   <= osc_s1_q;
      osc_s3_q   <= osc_s2_q;
      if (osc_s2_q == osc_s3_q) osc_lvl_q <= osc_s3_q;
      osc_prev_q <= osc_lvl_q;
    end
  end

  // Command arming: enable and command bits live for four cycles awaiting the store; the interrupt enable stays
  always_ff @(posedge clk) begin
    if (srst) begin
      self_program_enable_q <= 1'b0;
      cmd_q   <= 4'h0;
      ie_q    <= 1'b0;
      win_q   <= 3'h0;
    end else if (ce) begin
      if (ctl_take) begin
        self_program_enable_q <= bus.ctrl_wdata[`SPS_CTL_EN];
        cmd_q   <= bus.ctrl_wdata[`SPS_CTL_REEN:`SPS_CTL_ERASE];
        ie_q    <= bus.ctrl_wdata[`SPS_CTL_IE];
        win_q   <= bus.ctrl_wdata[`SPS_CTL_EN] ? `SPS_CMD_WINDOW : 3'h0;
      end else if (fire || (self_program_enable_q && !prog && win_q == 3'h1)) begin
        // Executed or timed out; timed ops hold enable through prog instead
        self_program_enable_q <= 1'b0;
        cmd_q   <= 4'h0;
        win_q   <= 3'h0;
      end else if (win_q != 3'h0) begin
        win_q <= win_q - 3'h1;
      end
    end
  end

  // Timed operation engine; a reset during a write lets it run out
  always_ff @(posedge clk) begin
    if (srst && !prog) begin
      st_q         <= sps_pkg::SPS_DEV_IDLE;
      tick_cnt_q   <= 16'h0000;
      flash_op_q   <= sps_pkg::SPS_OP_NONE;
      flash_page_q <= 7'h00;
      flash_lock_q <= 4'hf;
      flash_done_q <= 1'b0;
    end else if (ce) begin
      flash_done_q <= 1'b0;
      case (st_q)
        sps_pkg::SPS_DEV_IDLE: begin
          if (fire && (cmd_q[0] || cmd_q[1] || cmd_q[2]) && !cmd_q[3]) begin
            st_q         <= sps_pkg::SPS_DEV_PROG;
            tick_cnt_q   <= 16'h0000;
            flash_page_q <= bus.zptr[13:`SPS_PAGE_LSB];
            if (cmd_q[0]) flash_op_q <= sps_pkg::SPS_OP_ERASE;
            else if (cmd_q[1]) flash_op_q <= sps_pkg::SPS_OP_WRITE;
            else begin
              flash_op_q   <= sps_pkg::SPS_OP_LOCK;
              flash_lock_q <= bus.sdata[5:2];
            end
          end
        end
        sps_pkg::SPS_DEV_PROG: begin
          // Duration counted in oscillator periods, never CPU cycles
          if (osc_tick) begin
            if (tick_cnt_q == TICKS_M1) begin
              st_q         <= sps_pkg::SPS_DEV_IDLE;
              flash_done_q <= 1'b1;
              flash_op_q   <= sps_pkg::SPS_OP_NONE;
            end else begin
              tick_cnt_q <= tick_cnt_q + 16'h0001;
            end
          end
        end
        default: st_q <= sps_pkg::SPS_DEV_IDLE;
      endcase
    end
  end

  // Temporary page buffer fill; no reset so a reset cannot wipe loaded data
  always_ff @(posedge clk) begin
    if (ce) begin
      if (fire && cmd_q == 4'h0) page_buf[bus.zptr[6:1]] <= bus.sdata;
      buf_rd_data_q <= page_buf[buf_rd_idx];
    end
  end

  // Section busy: set by erase or write below the blocking region, cleared by re-enable
  always_ff @(posedge clk) begin
    if (srst && !prog) begin
      rw_section_busy_flag_q <= 1'b0;
    end else if (ce) begin
      if (fire && (cmd_q[0] || cmd_q[1]) && !cmd_q[3] &&
          bus.zptr[13:`SPS_PAGE_LSB] < BLOCK_PAGE) begin
        rw_section_busy_flag_q <= 1'b1;
      end else if (fire && cmd_q == 4'h8) begin
        rw_section_busy_flag_q <= 1'b0;
      end
    end
  end

  // Fetch gate: readable-section words refused while busy; lock writes leave all readable
  always_ff @(posedge clk) begin
    if (srst) begin
      fetch_ok_q <= 1'b1;
    end else if (ce) begin
      fetch_ok_q <= !((rw_section_busy_flag_q ||
                       (prog && flash_op_q != sps_pkg::SPS_OP_LOCK &&
                        flash_page_q < BLOCK_PAGE)) &&
                      fetch_addr < BLOCK_WORD);
    end
  end

  // Fuse strap caught by a clocked stage; boot and application limits
  always_ff @(posedge clk) begin
    if (srst) begin
      boot_sel_q   <= 2'b11;
      boot_start_q <= 16'h0000;
      app_end_q    <= 16'h0000;
    end else if (ce) begin
      boot_sel_q   <= boot_size_sel;
      boot_start_q <= boot_base(boot_sel_q);
      app_end_q    <= boot_base(boot_sel_q) - 16'h0001;
    end
  end

  // Status back to the core; enable reads set for the whole timed span
  always_ff @(posedge clk) begin
    if (srst) begin
      bus.ctrl_rdata        <= `SPS_CTL_RST;
      bus.eeprom_write_busy <= 1'b0;
      spm_irq_q             <= 1'b0;
    end else if (ce) begin
      bus.ctrl_rdata <= {ie_q, rw_section_busy_flag_q, 1'b0, cmd_q,
                         self_program_enable_q || prog};
      bus.eeprom_write_busy <= eeprom_write_busy;
      spm_irq_q <= ie_q && !(self_program_enable_q || prog);
    end
  end
endmodule

// File: inc/sps_cfg.svh
// Constants of the self-program flash sequencer: offsets, fields, resets, timing
`ifndef SPS_CFG_SVH
`define SPS_CFG_SVH
// Control register bit positions
`define SPS_CTL_EN     0
`define SPS_CTL_ERASE  1
`define SPS_CTL_WRITE  2
`define SPS_CTL_LOCK   3
`define SPS_CTL_REEN   4
`define SPS_CTL_SBUSY  6
`define SPS_CTL_IE     7
`define SPS_CTL_RST    8'h00
// Store instruction must follow the control write within this many cycles
`define SPS_CMD_WINDOW 3'h4
// Flash write time, microseconds
`define SPS_T_MIN_US   3700
`define SPS_T_MAX_US   4500
// Nominal RC oscillator rate, kHz
`define SPS_OSC_KHZ    8000
// Geometry
`define SPS_PC_W       13
`define SPS_PAGE_LSB   7
`define SPS_BOOT_MIN   16'h0200
`define SPS_FLASH16    16'h4000
`define SPS_FLASH8     16'h2000
`define SPS_NRWW16     16'h3000
`define SPS_NRWW8      16'h1000
// Host APB register offsets
`define SPS_REG_CMD    8'h00
`define SPS_REG_ZPTR   8'h04
`define SPS_REG_DATA   8'h08
`define SPS_REG_STAT   8'h0c
`endif

// File: inc/sps_pkg.sv
// Types shared by both ends of the self-program flash sequencer
package sps_pkg;
  typedef enum logic [1:0] {
    SPS_DEV_IDLE = 2'b00,
    SPS_DEV_PROG = 2'b01
  } sps_dev_state_t;
  typedef enum logic [1:0] {
    SPS_OP_NONE  = 2'b00,
    SPS_OP_ERASE = 2'b01,
    SPS_OP_WRITE = 2'b10,
    SPS_OP_LOCK  = 2'b11
  } sps_op_t;
  typedef enum logic [2:0] {
    SPS_HST_IDLE = 3'b000,
    SPS_HST_POLL = 3'b001,
    SPS_HST_EE   = 3'b010,
    SPS_HST_WR   = 3'b011,
    SPS_HST_SPM  = 3'b100
  } sps_hst_state_t;
endpackage

// File: inc/sps_if.sv
// Link between the boot-loader core and the self-program sequencer
`timescale 1ns/10ps
interface sps_if;
  logic        ctrl_wr;
  logic [7:0]  ctrl_wdata;
  logic [7:0]  ctrl_rdata;
  logic        store;
  logic [15:0] zptr;
  logic [15:0] sdata;
  logic        eeprom_write_busy;
  modport dev  (input ctrl_wr, ctrl_wdata, store, zptr, sdata,
                output ctrl_rdata, eeprom_write_busy);
  modport host (output ctrl_wr, ctrl_wdata, store, zptr, sdata,
                input ctrl_rdata, eeprom_write_busy);
endinterface

// File: rtl/sps_host.sv
// Boot-loader end: APB command registers and the timed store sequence
`include "sps_cfg.svh"
`timescale 1ns/10ps
module sps_host (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  sps_if.host              bus,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata_q,
  output logic             pready_q,
  output logic             pslverr_q
);
  sps_pkg::sps_hst_state_t st_q;
  logic [7:0]  cmd_q;
  logic [15:0] z_q;
  logic [15:0] data_q;
  logic        wr_go;
  logic        known;

  assign known = (paddr == `SPS_REG_CMD) || (paddr == `SPS_REG_ZPTR) ||
                 (paddr == `SPS_REG_DATA) || (paddr == `SPS_REG_STAT);
  // Write accepted at the access edge; a command is refused while busy
  assign wr_go = psel && penable && pready_q && pwrite;

  // APB answer: ready in the first cycle of the access phase, no wait state
  always_ff @(posedge clk) begin
    if (srst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (ce) begin
      if (psel && !penable) begin
        pready_q  <= 1'b1;
        pslverr_q <= !known;
        case (paddr)
          `SPS_REG_CMD:  prdata_q <= {24'h00_0000, cmd_q};
          `SPS_REG_ZPTR: prdata_q <= {16'h0000, z_q};
          `SPS_REG_DATA: prdata_q <= {16'h0000, data_q};
          `SPS_REG_STAT: prdata_q <= {16'h0000, bus.ctrl_rdata, 6'h00,
                                      bus.eeprom_write_busy,
                                      st_q != sps_pkg::SPS_HST_IDLE};
          default:       prdata_q <= 32'h0000_0000;
        endcase
      end else begin
        pready_q  <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  // Pointer and data words
  always_ff @(posedge clk) begin
    if (srst) begin
      z_q    <= 16'h0000;
      data_q <= 16'h0000;
    end else if (ce && wr_go) begin
      if (paddr == `SPS_REG_ZPTR) z_q <= pwdata[15:0];
      if (paddr == `SPS_REG_DATA) data_q <= pwdata[15:0];
    end
  end

  // Sequence runs without a break, standing in for masked interrupts
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q           <= sps_pkg::SPS_HST_IDLE;
      cmd_q          <= `SPS_CTL_RST;
      bus.ctrl_wr    <= 1'b0;
      bus.ctrl_wdata <= `SPS_CTL_RST;
      bus.store      <= 1'b0;
      bus.zptr       <= 16'h0000;
      bus.sdata      <= 16'h0000;
    end else if (ce) begin
      bus.ctrl_wr <= 1'b0;
      bus.store   <= 1'b0;
      case (st_q)
        sps_pkg::SPS_HST_IDLE: begin
          if (wr_go && paddr == `SPS_REG_CMD) begin
            cmd_q <= pwdata[7:0];
            st_q  <= sps_pkg::SPS_HST_POLL;
          end
        end
        sps_pkg::SPS_HST_POLL: begin
          if (!bus.ctrl_rdata[`SPS_CTL_EN]) st_q <= sps_pkg::SPS_HST_EE;
        end
        sps_pkg::SPS_HST_EE: begin
          if (!bus.eeprom_write_busy) begin
            bus.ctrl_wr    <= 1'b1;
            bus.ctrl_wdata <= cmd_q;
            st_q           <= sps_pkg::SPS_HST_WR;
          end
        end
        sps_pkg::SPS_HST_WR: begin
          // Store follows one cycle after the control write
          bus.store <= 1'b1;
          bus.sdata <= data_q;
          if (cmd_q[`SPS_CTL_WRITE]) bus.zptr <= {z_q[15:7], 7'h00};
          else bus.zptr <= {z_q[15:1], 1'b0};
          st_q <= sps_pkg::SPS_HST_SPM;
        end
        sps_pkg::SPS_HST_SPM: st_q <= sps_pkg::SPS_HST_IDLE;
        default: st_q <= sps_pkg::SPS_HST_IDLE;
      endcase
    end
  end
endmodule

// File: test/sps_link_sva.sv
// Checker on the link between the boot-loader end and the sequencer
`timescale 1ns/10ps
module sps_link_sva (
  input logic        clk,
  input logic        srst,
  input logic        ctrl_wr,
  input logic [7:0]  ctrl_wdata,
  input logic [7:0]  ctrl_rdata,
  input logic        store,
  input logic [15:0] zptr,
  input logic        eeprom_write_busy
);
  logic [7:0]  reen_q;
  logic [15:0] en_q;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Cycles since the last re-enable write; saturates so an old one never looks fresh
  always_ff @(posedge clk) begin
    if (srst) reen_q <= 8'hff;
    else if (ctrl_wr && ctrl_wdata[4]) reen_q <= 8'h00;
    else if (reen_q != 8'hff) reen_q <= reen_q + 8'h01;
  end
  // Length of the current stretch with the enable bit set
  always_ff @(posedge clk) begin
    if (srst || !ctrl_rdata[0]) en_q <= 16'h0000;
    else if (en_q != 16'hffff) en_q <= en_q + 16'h0001;
  end
  a_wr_one_cycle: assert property (ctrl_wr |=> !ctrl_wr)
    else $error("control write held past one cycle");
  a_store_follows: assert property (ctrl_wr |=> store && $stable(zptr[0]))
    else $error("store not issued right after control write");
  a_store_needs_wr: assert property (store |-> $past(ctrl_wr))
    else $error("store without a control write just before");
  a_z0_clear: assert property (store |-> zptr[0] == 1'b0)
    else $error("pointer byte bit set on store");
  a_write_z_clear: assert property (store && $past(ctrl_wdata[6:0]) == 7'h05 |-> zptr[6:0] == 7'h00)
    else $error("word field not zero on page write");
  a_wr_ee_idle: assert property (ctrl_wr |-> !eeprom_write_busy)
    else $error("control write during eeprom write");
  a_wr_en_clear: assert property (ctrl_wr |-> !ctrl_rdata[0])
    else $error("control write while enable bit set");
  a_busy_shows: assert property (ctrl_wr && ctrl_wdata[3:1] != 3'h0 |-> ##[1:4] ctrl_rdata[0])
    else $error("enable bit not seen after timed command");
  a_busy_clear_reen: assert property ($fell(ctrl_rdata[6]) |-> reen_q < 8'h08)
    else $error("section busy cleared without re-enable");
  a_op_bounded: assert property (en_q < 16'h00c8)
    else $error("enable bit held far too long");
endmodule

// File: test/sps_tb.sv
// Self-checking bench joining both ends of the self-program sequencer
`timescale 1ns/10ps
`include "sps_cfg.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module sps_tb;
  logic             clk, srst, ce, psel, penable, pwrite, rc_osc, ee, pready, pslverr, er;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic [1:0]       boot_size_sel;
  logic [12:0]      fetch_addr;
  logic [5:0]       buf_rd_idx;
  sps_pkg::sps_op_t flash_op_q;
  logic [6:0]       flash_page_q;
  logic [3:0]       flash_lock_q;
  logic             flash_done_q, sbusy_q, fetch_ok_q, spm_irq_q;
  logic [15:0]      buf_rd_data_q, boot_start_q, app_end_q;
  int               failures, tests_run, n;
  sps_if lnk ();
  sps_host u_sps_host (.clk(clk), .srst(srst), .ce(ce), .bus(lnk.host), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata),
    .pready_q(pready), .pslverr_q(pslverr));
  // Short timed count keeps each flash operation to under two dozen cycles
  sps_device #(.FLASH_16K(1'b1), .PROG_TICKS(4)) u_sps_device (.clk(clk), .srst(srst),
    .ce(ce), .bus(lnk.dev), .rc_osc(rc_osc), .eeprom_write_busy(ee),
    .boot_size_sel(boot_size_sel), .fetch_addr(fetch_addr), .buf_rd_idx(buf_rd_idx),
    .flash_op_q(flash_op_q), .flash_page_q(flash_page_q), .flash_lock_q(flash_lock_q),
    .flash_done_q(flash_done_q), .buf_rd_data_q(buf_rd_data_q),
    .rw_section_busy_flag_q(sbusy_q), .fetch_ok_q(fetch_ok_q), .boot_start_q(boot_start_q),
    .app_end_q(app_end_q), .spm_irq_q(spm_irq_q));
  sps_link_sva u_sps_link_sva (.clk(clk), .srst(srst), .ctrl_wr(lnk.ctrl_wr),
    .ctrl_wdata(lnk.ctrl_wdata), .ctrl_rdata(lnk.ctrl_rdata), .store(lnk.store),
    .zptr(lnk.zptr), .eeprom_write_busy(lnk.eeprom_write_busy));
  // Oscillator period unrelated to the core clock, as on silicon
  always #5 clk = ~clk;
  always #21.7 rc_osc = ~rc_osc;
  task report_and_stop;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Bounded wait on a design condition; a hang ends the run as a failure
  `define WAITC(c) begin n = 0; while (!(c) && n < 3000) begin @(posedge clk); n++; end \
    if (n >= 3000) begin failures++; report_and_stop(); end end
  // One APB transfer: setup, then access held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    `WAITC(pready === 1'b1)
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll status until the sequence and the enable bit are both clear
  task idle;
    int k;
    for (k = 0; k < 200; k++) begin
      apb(1'b0, `SPS_REG_STAT, 32'h0);
      if (rd[0] === 1'b0 && rd[8] === 1'b0) break;
    end
    if (k >= 200) begin failures++; report_and_stop(); end
  endtask
  task reen;
    idle; apb(1'b1, `SPS_REG_CMD, 32'h11); idle;
    `CHK("busy_clr", 1'b0, sbusy_q)
    `CHK("fetch_back", 1'b1, fetch_ok_q)
  endtask
  // Timed operation: target, section guard, optional reset mid-flight, duration
  task do_op(input logic [7:0] cmd, input logic [15:0] z, input sps_pkg::sps_op_t op,
             input logic [6:0] pg, input bit mid_rst);
    int c;
    c = 0;
    idle; apb(1'b1, `SPS_REG_ZPTR, {16'h0, z}); apb(1'b1, `SPS_REG_CMD, {24'h0, cmd});
    `WAITC(flash_op_q !== sps_pkg::SPS_OP_NONE)
    @(posedge clk);
    `CHK("op", op, flash_op_q)
    if (op != sps_pkg::SPS_OP_LOCK) `CHK("page", pg, flash_page_q)
    `CHK("busy_set", op != sps_pkg::SPS_OP_LOCK && pg < 7'h60, sbusy_q)
    `CHK("fetch", op == sps_pkg::SPS_OP_LOCK || pg >= 7'h60, fetch_ok_q)
    if (mid_rst) begin
      srst <= 1'b1; repeat (2) @(posedge clk); srst <= 1'b0; c = 3;
      `CHK("op_kept", op, flash_op_q)
    end
    while (flash_done_q !== 1'b1 && c < 100) begin @(posedge clk); c++; end
    `CHK("dur_ok", 1'b1, c >= 12 && c <= 40)
    repeat (4) @(posedge clk);
    `CHK("busy_hold", op != sps_pkg::SPS_OP_LOCK && pg < 7'h60, sbusy_q)
  endtask
  task fill(input logic [15:0] z, input logic [15:0] d);
    idle; apb(1'b1, `SPS_REG_ZPTR, {16'h0, z}); apb(1'b1, `SPS_REG_DATA, {16'h0, d});
    apb(1'b1, `SPS_REG_CMD, 32'h01); idle;
    buf_rd_idx <= z[6:1];
    repeat (2) @(posedge clk);
    `CHK("buf", d, buf_rd_data_q)
  endtask
  task t_map;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk); boot_size_sel <= i[1:0]; repeat (3) @(posedge clk);
      `CHK("boot", `SPS_FLASH16 - (`SPS_BOOT_MIN << (3 - i)), boot_start_q)
      `CHK("app_end", `SPS_FLASH16 - (`SPS_BOOT_MIN << (3 - i)) - 16'h1, app_end_q)
    end
    $display("test boot map done");
  endtask
  task t_erase_write;
    fetch_addr <= 13'h0100;
    do_op(8'h03, 16'h0280, sps_pkg::SPS_OP_ERASE, 7'h05, 1'b1); reen;
    do_op(8'h03, 16'h3000, sps_pkg::SPS_OP_ERASE, 7'h60, 1'b0);
    fill(16'h02fe, 16'hbeef); fill(16'h0280, 16'h1234);
    do_op(8'h85, 16'h02fe, sps_pkg::SPS_OP_WRITE, 7'h05, 1'b0);
    idle; `CHK("irq_on", 1'b1, spm_irq_q)
    reen; `CHK("irq_off", 1'b0, spm_irq_q)
    $display("test erase and write done");
  endtask
  task t_lock_ee;
    apb(1'b1, `SPS_REG_DATA, 32'h00c3);
    do_op(8'h09, 16'h0000, sps_pkg::SPS_OP_LOCK, 7'h00, 1'b0);
    `CHK("lock", 4'h0, flash_lock_q)
    idle; ee <= 1'b1;
    apb(1'b1, `SPS_REG_ZPTR, 32'h0380); apb(1'b1, `SPS_REG_CMD, 32'h03);
    repeat (10) @(posedge clk);
    `CHK("ee_block", sps_pkg::SPS_OP_NONE, flash_op_q)
    ee <= 1'b0;
    `WAITC(flash_op_q === sps_pkg::SPS_OP_ERASE)
    `WAITC(flash_done_q === 1'b1)
    reen;
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped_err", 1'b1, er)
    `CHK("unmapped_rd", 32'h0, rd)
    $display("test lock and eeprom guard done");
  endtask
  initial begin
    clk = 0; srst = 1; ce = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    rc_osc = 0; ee = 0; boot_size_sel = 0; fetch_addr = 0; buf_rd_idx = 0;
    failures = 0; tests_run = 0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    `CHK("rst_fetch", 1'b1, fetch_ok_q)
    `CHK("rst_lock", 4'hf, flash_lock_q)
    t_map;
    t_erase_write;
    t_lock_ee;
    report_and_stop;
  end
endmodule
